/* rtl/vpi_ctrl.sv */
// Vectored fixed-priority interrupt controller with a classic Wishbone register port.
// Assumes the core stalls while busy is high and takes push bytes and vectors as they come.
//
// Implementation choices: the address map and the Wishbone register port.
`timescale 1ns/1ps

module vpi_ctrl #(
  parameter int NUM_SRC = vpi_pkg::SRC_COUNT
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  // Wishbone slave
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [7:0]           wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic      [31:0]          wb_dat_o,
  output logic                      wb_ack_o,
  // Request sources
  input  wire vpi_pkg::vpi_pins_t   pins,
  input  wire logic [7:0]           port0InMode,
  input  wire vpi_pkg::vpi_periph_t periph,
  // Core sequencer
  input  wire vpi_pkg::vpi_core_in_t core,
  output logic                      busy,
  output logic                      pushValid,
  output logic      [7:0]           pushData,
  output logic                      vecValid,
  output logic      [15:0]          vecAddrLo,
  output logic      [15:0]          vecAddrHi,
  output logic                      maskFlag
);

  // Priority encoder and vector arithmetic are sized for the fixed source set
  if (NUM_SRC != vpi_pkg::SRC_COUNT) begin : g_badCount
    $error("vpi_ctrl serves exactly fifteen maskable sources");
  end

  // Pin synchronisers: first stage read only by the second
  logic [12:0] pinMeta;
  logic [12:0] pinSync;
  logic [12:0] pinPrev;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pinMeta <= 13'h0000;
      pinSync <= 13'h0000;
      pinPrev <= 13'h0000;
    end else begin
      pinMeta <= pins;
      pinSync <= pinMeta;
      pinPrev <= pinSync;
    end
  end

  logic [7:0] ctrlReg;
  logic [3:0] srcSetReg;
  logic [14:0] reqReg;
  logic [14:0] enaReg;
  logic [3:0] discReg;

  // Edge pick: rising when the edge bit is 1, falling otherwise
  function automatic logic edgeHit(input logic cur, input logic prv, input logic rising);
    edgeHit = rising ? (cur & ~prv) : (~cur & prv);
  endfunction

  // Key wakeup: AND of input-mode port 0 levels falls
  logic keyAndNow;
  logic keyAndPrev;
  logic keyFall;
  assign keyAndNow  = &(pinSync[7:0] | ~port0InMode);
  assign keyAndPrev = &(pinPrev[7:0] | ~port0InMode);
  assign keyFall    = keyAndPrev & ~keyAndNow;

  logic keyEv;
  logic collEv;
  logic adEv;
  logic t1Ev;
  assign keyEv  = keyFall & srcSetReg[vpi_pkg::SS_KEY];
  assign collEv = periph.busColl & srcSetReg[vpi_pkg::SS_COLL];
  assign adEv   = periph.adDone & srcSetReg[vpi_pkg::SS_AD];
  assign t1Ev   = periph.tmr1 & srcSetReg[vpi_pkg::SS_T1];

  // Event vector in priority order
  logic [14:0] srcEv;
  always_comb begin
    srcEv = 15'h0000;
    srcEv[vpi_pkg::SRC_SER1_RX] = periph.ser1Rx & ctrlReg[vpi_pkg::CT_SER1_SEL];
    srcEv[vpi_pkg::SRC_SER1_TX] = periph.ser1Tx & ctrlReg[vpi_pkg::CT_SER1_SEL];
    srcEv[vpi_pkg::SRC_SER2_RX] = periph.ser2Rx & ctrlReg[vpi_pkg::CT_SER2_SEL];
    srcEv[vpi_pkg::SRC_SER2_TX] = periph.ser2Tx & ctrlReg[vpi_pkg::CT_SER2_SEL];
    srcEv[vpi_pkg::SRC_EXT0] = edgeHit(pinSync[12], pinPrev[12],
                                       ctrlReg[vpi_pkg::CT_EDGE_EXT0]);
    srcEv[vpi_pkg::SRC_EXT1] = edgeHit(pinSync[11], pinPrev[11],
                                       ctrlReg[vpi_pkg::CT_EDGE_EXT1]);
    srcEv[vpi_pkg::SRC_KEY_COLL] = keyEv | collEv;
    srcEv[vpi_pkg::SRC_CNTR] = edgeHit(pinSync[10], pinPrev[10],
                                       ctrlReg[vpi_pkg::CT_EDGE_CNTR]);
    srcEv[vpi_pkg::SRC_CAP0] = edgeHit(pinSync[9], pinPrev[9],
                                       ctrlReg[vpi_pkg::CT_EDGE_CAP0]);
    srcEv[vpi_pkg::SRC_CAP1] = edgeHit(pinSync[8], pinPrev[8],
                                       ctrlReg[vpi_pkg::CT_EDGE_CAP1]);
    srcEv[vpi_pkg::SRC_CMP]  = periph.cmpMatch & ctrlReg[vpi_pkg::CT_CMP_SEL];
    srcEv[vpi_pkg::SRC_TMRX] = periph.tmrX;
    srcEv[vpi_pkg::SRC_TMRA] = periph.tmrA;
    srcEv[vpi_pkg::SRC_TMRB] = periph.tmrB;
    srcEv[vpi_pkg::SRC_AD_T1] = adEv | t1Ev;
  end

  // Priority pick over accepted requests
  logic [14:0] acceptable;
  logic        anyAccept;
  logic [3:0]  winIdx;
  assign acceptable = reqReg & enaReg & {15{~maskFlag}};
  assign anyAccept  = |acceptable;
  always_comb begin
    winIdx = 4'h0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (acceptable[i]) begin
        winIdx = 4'(i);
      end
    end
  end

  logic brkPending;
  logic boundary;
  vpi_pkg::vpi_state_t state;
  assign boundary = core.instrDone & (state == vpi_pkg::ST_IDLE);

  logic        takeSrc;
  logic        takeBrk;
  logic [15:0] winVec;
  assign takeSrc = boundary & anyAccept;
  assign takeBrk = boundary & ~anyAccept & brkPending;
  assign winVec  = vpi_pkg::VEC_FIRST_SRC - 16'(winIdx) * vpi_pkg::VEC_STEP;

  // Wishbone decode
  logic       wbReq;
  logic       wbWr;
  logic [3:0] regHit;
  logic [14:0] reqWrClr;
  logic [3:0] discWrClr;
  assign wbReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wbWr  = wbReq & wb_we_i;
  always_comb begin
    regHit = 4'h0;
    if (wb_adr_i == vpi_pkg::OFS_REQUEST) begin
      regHit = 4'h1;
    end else if (wb_adr_i == vpi_pkg::OFS_ENABLE) begin
      regHit = 4'h2;
    end else if (wb_adr_i == vpi_pkg::OFS_SRCSET) begin
      regHit = 4'h3;
    end else if (wb_adr_i == vpi_pkg::OFS_DISCRIM) begin
      regHit = 4'h4;
    end else if (wb_adr_i == vpi_pkg::OFS_CONTROL) begin
      regHit = 4'h5;
    end else if (wb_adr_i == vpi_pkg::OFS_STATUS) begin
      regHit = 4'h6;
    end
  end

  // Zeros written clear, ones leave alone
  always_comb begin
    reqWrClr = 15'h0000;
    if (wbWr && regHit == 4'h1) begin
      if (wb_sel_i[0]) begin
        reqWrClr[7:0] = ~wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        reqWrClr[14:8] = ~wb_dat_i[14:8];
      end
    end
  end
  assign discWrClr = (wbWr && regHit == 4'h4 && wb_sel_i[0]) ? ~wb_dat_i[3:0] : 4'h0;

  // Request bits: event set beats software and acceptance clears
  logic [14:0] accClr;
  assign accClr = takeSrc ? (15'h0001 << winIdx) : 15'h0000;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reqReg <= 15'h0000;
    end else begin
      reqReg <= (reqReg & ~reqWrClr & ~accClr) | srcEv;
    end
  end

  // Which shared contributor fired
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      discReg <= 4'h0;
    end else begin
      discReg <= (discReg & ~discWrClr) | {t1Ev, adEv, collEv, keyEv};
    end
  end

  localparam logic [14:0] RST_ENA = vpi_pkg::RST_ENABLE[14:0];

  // Software-owned registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      enaReg    <= RST_ENA;
      srcSetReg <= vpi_pkg::RST_SRCSET;
      ctrlReg   <= vpi_pkg::RST_CONTROL;
    end else if (wbWr) begin
      if (regHit == 4'h2 && wb_sel_i[0]) begin
        enaReg[7:0] <= wb_dat_i[7:0];
      end
      if (regHit == 4'h2 && wb_sel_i[1]) begin
        enaReg[14:8] <= wb_dat_i[14:8];
      end
      if (regHit == 4'h3 && wb_sel_i[0]) begin
        srcSetReg <= wb_dat_i[3:0];
      end
      if (regHit == 4'h5 && wb_sel_i[0]) begin
        ctrlReg <= wb_dat_i[7:0];
      end
    end
  end

  // Break trap waits for a boundary with no acceptable source, never masked
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      brkPending <= 1'b0;
    end else begin
      brkPending <= core.breakSoftwareTrap | (brkPending & ~takeBrk);
    end
  end

  // Bus answer: one wait-state registered ack
  logic [31:0] rdData;
  logic [4:0]  lastIdx;
  always_comb begin
    rdData = 32'h0000_0000;
    case (regHit)
      4'h1: rdData[14:0] = reqReg;
      4'h2: rdData[14:0] = enaReg;
      4'h3: rdData[3:0]  = srcSetReg;
      4'h4: rdData[3:0]  = discReg;
      4'h5: rdData[7:0]  = ctrlReg;
      4'h6: rdData[7:0]  = {brkPending, lastIdx, busy, maskFlag};
      default: rdData = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wbReq;
      wb_dat_o <= wbReq ? rdData : 32'h0000_0000;
    end
  end

  // Acceptance sequencer
  logic [15:0] pcHold;
  logic [7:0]  psHold;
  logic [15:0] vecHold;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state   <= vpi_pkg::ST_RESET;
      pcHold  <= 16'h0000;
      psHold  <= 8'h00;
      vecHold <= 16'h0000;
      lastIdx <= 5'h1f;
    end else begin
      case (state)
        vpi_pkg::ST_RESET: begin
          state <= vpi_pkg::ST_IDLE;
        end
        vpi_pkg::ST_IDLE: begin
          if (takeSrc || takeBrk) begin
            state   <= vpi_pkg::ST_PCH;
            pcHold  <= core.pc;
            psHold  <= core.status;
            vecHold <= takeSrc ? winVec : vpi_pkg::VEC_BREAK;
            lastIdx <= takeSrc ? {1'b0, winIdx} : 5'h10;
          end
        end
        vpi_pkg::ST_PCH: begin
          state <= vpi_pkg::ST_PCL;
        end
        vpi_pkg::ST_PCL: begin
          state <= vpi_pkg::ST_PS;
        end
        vpi_pkg::ST_PS: begin
          state <= vpi_pkg::ST_IDLE;
        end
        default: begin
          state <= vpi_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Push bytes in order PC high, PC low, status with the old mask bit
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pushValid <= 1'b0;
      pushData  <= 8'h00;
    end else begin
      pushValid <= 1'b0;
      pushData  <= 8'h00;
      if (state == vpi_pkg::ST_IDLE && (takeSrc || takeBrk)) begin
        pushValid <= 1'b1;
        pushData  <= core.pc[15:8];
      end else if (state == vpi_pkg::ST_PCH) begin
        pushValid <= 1'b1;
        pushData  <= pcHold[7:0];
      end else if (state == vpi_pkg::ST_PCL) begin
        pushValid <= 1'b1;
        pushData  <= {psHold[7:3], maskFlag, psHold[1:0]};
      end
    end
  end

  // Vector pair to the core: reset vector on leaving reset, else concurrent with the PC low push
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      vecValid  <= 1'b0;
      vecAddrLo <= 16'h0000;
      vecAddrHi <= 16'h0000;
    end else begin
      vecValid <= 1'b0;
      if (state == vpi_pkg::ST_RESET) begin
        vecValid  <= 1'b1;
        vecAddrLo <= vpi_pkg::VEC_RESET;
        vecAddrHi <= vpi_pkg::VEC_RESET + 16'h0001;
      end else if (state == vpi_pkg::ST_PCH) begin
        vecValid  <= 1'b1;
        vecAddrLo <= vecHold;
        vecAddrHi <= vecHold + 16'h0001;
      end
    end
  end

  // Core stalls from acceptance until the status byte is out
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy <= 1'b1;
    end else begin
      busy <= (state == vpi_pkg::ST_IDLE) ? (takeSrc | takeBrk)
                                          : (state != vpi_pkg::ST_PS);
    end
  end

  // Global mask flag; acceptance sets it only after the status push
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      maskFlag <= 1'b1;
    end else if (state == vpi_pkg::ST_PS) begin
      maskFlag <= 1'b1;
    end else if (core.returnFromTrapInstruction) begin
      maskFlag <= core.poppedStatus[vpi_pkg::PS_MASK_BIT];
    end else if (core.setMaskInstruction) begin
      maskFlag <= 1'b1;
    end else if (core.clearMaskInstruction) begin
      maskFlag <= 1'b0;
    end
  end

endmodule

/* rtl/vpi_pkg.sv */
// Constants, register map and carrier types of the vectored priority interrupt controller.
// Assumes a 32-bit classic Wishbone slave port and an 8-bit core with a 16-bit program counter.
package vpi_pkg;

  // Maskable sources, index 0 is the most urgent one after reset
  localparam int SRC_COUNT = 15;
  localparam logic [3:0] SRC_SER1_RX  = 4'h0;
  localparam logic [3:0] SRC_SER1_TX  = 4'h1;
  localparam logic [3:0] SRC_SER2_RX  = 4'h2;
  localparam logic [3:0] SRC_SER2_TX  = 4'h3;
  localparam logic [3:0] SRC_EXT0     = 4'h4;
  localparam logic [3:0] SRC_EXT1     = 4'h5;
  localparam logic [3:0] SRC_KEY_COLL = 4'h6;
  localparam logic [3:0] SRC_CNTR     = 4'h7;
  localparam logic [3:0] SRC_CAP0     = 4'h8;
  localparam logic [3:0] SRC_CAP1     = 4'h9;
  localparam logic [3:0] SRC_CMP      = 4'ha;
  localparam logic [3:0] SRC_TMRX     = 4'hb;
  localparam logic [3:0] SRC_TMRA     = 4'hc;
  localparam logic [3:0] SRC_TMRB     = 4'hd;
  localparam logic [3:0] SRC_AD_T1    = 4'he;

  // Vector low-byte addresses; the high byte always sits one above
  localparam logic [15:0] VEC_RESET     = 16'hfffc;
  localparam logic [15:0] VEC_FIRST_SRC = 16'hfffa;
  localparam logic [15:0] VEC_STEP      = 16'h0002;
  localparam logic [15:0] VEC_BREAK     = 16'hffdc;

  // Processor status bit holding the global mask flag
  localparam int PS_MASK_BIT = 2;

  // Wishbone byte offsets
  localparam logic [7:0] OFS_REQUEST = 8'h00;
  localparam logic [7:0] OFS_ENABLE  = 8'h04;
  localparam logic [7:0] OFS_SRCSET  = 8'h08;
  localparam logic [7:0] OFS_DISCRIM = 8'h0c;
  localparam logic [7:0] OFS_CONTROL = 8'h10;
  localparam logic [7:0] OFS_STATUS  = 8'h14;

  // Source set and discrimination bit positions
  localparam int SS_KEY  = 0;
  localparam int SS_COLL = 1;
  localparam int SS_AD   = 2;
  localparam int SS_T1   = 3;

  // Control register bit positions (edge bits: 1 rising, 0 falling)
  localparam int CT_EDGE_EXT0 = 0;
  localparam int CT_EDGE_EXT1 = 1;
  localparam int CT_EDGE_CNTR = 2;
  localparam int CT_EDGE_CAP0 = 3;
  localparam int CT_EDGE_CAP1 = 4;
  localparam int CT_SER1_SEL  = 5;
  localparam int CT_SER2_SEL  = 6;
  localparam int CT_CMP_SEL   = 7;

  // Reset values
  localparam logic [15:0] RST_ENABLE  = 16'h0000;
  localparam logic [3:0]  RST_SRCSET  = 4'h0;
  localparam logic [7:0]  RST_CONTROL = 8'h00;

  // On-chip peripheral events, one-cycle pulses on clk
  typedef struct packed {
    logic ser1Rx;
    logic ser1Tx;
    logic ser2Rx;
    logic ser2Tx;
    logic busColl;
    logic cmpMatch;
    logic tmrX;
    logic tmrA;
    logic tmrB;
    logic adDone;
    logic tmr1;
  } vpi_periph_t;

  // External pins, asynchronous
  typedef struct packed {
    logic       extReqZero;
    logic       extReqOne;
    logic       counterPinZero;
    logic       capZero;
    logic       capOne;
    logic [7:0] port0;
  } vpi_pins_t;

  // Core sequencer strobes, one-cycle pulses on clk
  typedef struct packed {
    logic       instrDone;
    logic       setMaskInstruction;
    logic       clearMaskInstruction;
    logic       returnFromTrapInstruction;
    logic       breakSoftwareTrap;
    logic [7:0] poppedStatus;
    logic [15:0] pc;
    logic [7:0] status;
  } vpi_core_in_t;

  typedef enum logic [2:0] {
    ST_RESET = 3'b000,
    ST_IDLE  = 3'b001,
    ST_PCH   = 3'b010,
    ST_PCL   = 3'b011,
    ST_PS    = 3'b100
  } vpi_state_t;

endpackage

/* testbench/tb_top.sv */
// Self-checking bench for the interrupt controller and a core stand-in.
// Assumes package, controller, checker and core model compile before it.
`timescale 1ns/1ps

module tb_top;
  logic                  clk;
  logic                  sys_rst;
  logic                  wbCyc;
  logic                  wbStb;
  logic                  wbWe;
  logic [7:0]            wbAdr;
  logic [31:0]           wbDatI;
  logic [31:0]           wbDatO;
  logic                  wbAck;
  vpi_pkg::vpi_pins_t    pins;
  vpi_pkg::vpi_periph_t  periph;
  vpi_pkg::vpi_core_in_t core;
  logic                  stepReq;
  logic [3:0]            op;
  logic [7:0]            popped;
  logic [7:0]            p0Mode;
  logic                  busy;
  logic                  pushValid;
  logic [7:0]            pushData;
  logic                  vecValid;
  logic [15:0]           vecAddrLo;
  logic [15:0]           vecAddrHi;
  logic                  maskFlag;
  logic [23:0]           pushLog;
  logic [15:0]           expPc;
  logic [31:0]           rdData;
  int                    n_errors;
  int                    n_compared;

  always #5 clk = ~clk;

  vpi_ctrl i_dut (
    .clk(clk), .sys_rst(sys_rst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
    .wb_adr_i(wbAdr), .wb_sel_i(4'hf), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO),
    .wb_ack_o(wbAck), .pins(pins), .port0InMode(p0Mode), .periph(periph), .core(core),
    .busy(busy), .pushValid(pushValid), .pushData(pushData), .vecValid(vecValid),
    .vecAddrLo(vecAddrLo), .vecAddrHi(vecAddrHi), .maskFlag(maskFlag));

  vpi_core_model i_core (
    .clk(clk), .sys_rst(sys_rst), .stepReq(stepReq), .op(op), .popped(popped),
    .busy(busy), .pushValid(pushValid), .pushData(pushData), .vecValid(vecValid),
    .vecAddrLo(vecAddrLo), .maskFlag(maskFlag), .core(core), .pushLog(pushLog));

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Holds the request until ack is sampled high
  task automatic wbXfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int t;
    t = 0;
    @(posedge clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbDatI <= dat;
    do begin
      @(posedge clk);
      t++;
    end while (wbAck !== 1'b1 && t < 20);
    check("bus ack", 32'h1, {31'h0, wbAck});
    rdData = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
  endtask

  task automatic rdCheck(input string what, input logic [7:0] adr, input logic [31:0] exp);
    wbXfer(1'b0, adr, 32'h0);
    check(what, exp, rdData);
  endtask

  task automatic pulseOp(input logic [3:0] code);
    @(posedge clk);
    op <= code;
    @(posedge clk);
    op <= 4'h0;
    // Let the edge's update settle before the caller looks
    @(negedge clk);
  endtask

  task automatic step(input logic take, input logic [15:0] vec, input logic [7:0] ps);
    logic        seen;
    logic [15:0] lo;
    logic [15:0] hi;
    seen = 1'b0;
    lo = 16'h0000;
    hi = 16'h0000;
    @(posedge clk);
    stepReq <= 1'b1;
    @(posedge clk);
    stepReq <= 1'b0;
    repeat (6) begin
      @(negedge clk);
      if (vecValid === 1'b1) begin
        seen = 1'b1;
        lo = vecAddrLo;
        hi = vecAddrHi;
      end
    end
    check("accepted", {31'h0, take}, {31'h0, seen});
    if (take) begin
      check("vector pair", {vec + 16'h0001, vec}, {hi, lo});
      check("stacked bytes", {8'h00, expPc, ps}, {8'h00, pushLog});
      check("mask after accept", 32'h1, {31'h0, maskFlag});
      expPc = vec;
    end
  endtask

  task automatic complete_run();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    #100000;
    n_errors++;
    $display("Error watchdog expected finish seen hang");
    complete_run();
  end

  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    {wbCyc, wbStb, wbWe, wbAdr, wbDatI} = '0;
    pins = '0;
    periph = '0;
    {stepReq, op, popped} = '0;
    p0Mode = 8'h00;
    n_errors = 0;
    n_compared = 0;
    expPc = 16'hfffc;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    check("reset vector", 32'hfffdfffc, {vecAddrHi, vecAddrLo});
    check("reset mask", 32'h1, {31'h0, maskFlag});
    repeat (2) @(posedge clk);
    // Unselected gated sources must stay silent
    @(posedge clk);
    periph <= vpi_pkg::vpi_periph_t'(11'h7ff);
    @(posedge clk);
    periph <= '0;
    rdCheck("gated requests", vpi_pkg::OFS_REQUEST, 32'h00003800);
    rdCheck("enable reset", vpi_pkg::OFS_ENABLE, 32'h0);
    wbXfer(1'b1, vpi_pkg::OFS_REQUEST, 32'h0);
    rdCheck("cleared requests", vpi_pkg::OFS_REQUEST, 32'h0);
    wbXfer(1'b1, vpi_pkg::OFS_CONTROL, 32'hff);
    wbXfer(1'b1, vpi_pkg::OFS_SRCSET, 32'h6);
    @(posedge clk);
    periph <= vpi_pkg::vpi_periph_t'(11'h7ff);
    pins <= vpi_pkg::vpi_pins_t'({5'h1f, 8'hff});
    @(posedge clk);
    periph <= '0;
    repeat (6) @(posedge clk);
    rdCheck("all requests", vpi_pkg::OFS_REQUEST, 32'h00007fff);
    rdCheck("discrimination", vpi_pkg::OFS_DISCRIM, 32'h6);
    wbXfer(1'b1, vpi_pkg::OFS_REQUEST, 32'hfffe);
    rdCheck("clear by zero", vpi_pkg::OFS_REQUEST, 32'h00007ffe);
    wbXfer(1'b1, vpi_pkg::OFS_REQUEST, 32'hffff);
    rdCheck("no set by one", vpi_pkg::OFS_REQUEST, 32'h00007ffe);
    pulseOp(4'h2);
    check("mask cleared", 32'h0, {31'h0, maskFlag});
    step(1'b0, 16'h0000, 8'h00);
    wbXfer(1'b1, vpi_pkg::OFS_ENABLE, 32'h7fff);
    pulseOp(4'h1);
    step(1'b0, 16'h0000, 8'h00);
    @(posedge clk);
    popped <= 8'h00;
    pulseOp(4'h4);
    check("mask popped", 32'h0, {31'h0, maskFlag});
    for (int i = 1; i < 15; i++) begin
      step(1'b1, 16'hfffa - 16'(2 * i), 8'h00);
      pulseOp(4'h2);
    end
    rdCheck("requests consumed", vpi_pkg::OFS_REQUEST, 32'h0);
    pulseOp(4'h1);
    pulseOp(4'h8);
    step(1'b1, 16'hffdc, 8'h04);
    // Mask set, idle, last index break, nothing pending
    rdCheck("status after break", vpi_pkg::OFS_STATUS, 32'h41);
    pulseOp(4'h2);
    @(posedge clk);
    popped <= 8'h04;
    pulseOp(4'h4);
    check("mask restored", 32'h1, {31'h0, maskFlag});
    // Falling edges, key wakeup and timer 1 on the shared slots
    wbXfer(1'b1, vpi_pkg::OFS_CONTROL, 32'h0);
    wbXfer(1'b1, vpi_pkg::OFS_SRCSET, 32'h9);
    @(posedge clk);
    p0Mode <= 8'hff;
    pins <= '0;
    periph <= vpi_pkg::vpi_periph_t'(11'h001);
    @(posedge clk);
    periph <= '0;
    repeat (6) @(posedge clk);
    rdCheck("falling requests", vpi_pkg::OFS_REQUEST, 32'h000043f0);
    rdCheck("sticky discrimination", vpi_pkg::OFS_DISCRIM, 32'hf);
    rdCheck("unmapped read", 8'h20, 32'h0);
    complete_run();
  end
endmodule

/* testbench/vpi_core_model.sv */
// Core sequencer stand-in: instruction boundaries, mask opcodes, vector jumps.
// Assumes the bench gives steps and opcodes as one-cycle levels on clk.
`timescale 1ns/1ps

module vpi_core_model (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // Bench commands
  input  wire logic             stepReq,
  input  wire logic [3:0]       op,
  input  wire logic [7:0]       popped,
  // Controller side
  input  wire logic             busy,
  input  wire logic             pushValid,
  input  wire logic [7:0]       pushData,
  input  wire logic             vecValid,
  input  wire logic [15:0]      vecAddrLo,
  input  wire logic             maskFlag,
  output vpi_pkg::vpi_core_in_t core,
  output logic      [23:0]      pushLog
);
  logic [15:0] pcReg;

  always_comb begin
    core.instrDone = stepReq && !busy;
    core.setMaskInstruction = op[0];
    core.clearMaskInstruction = op[1];
    core.returnFromTrapInstruction = op[2];
    core.breakSoftwareTrap = op[3];
    // Stale outside a return, so show garbage
    core.poppedStatus = op[2] ? popped : ~popped;
    core.pc = pcReg;
    core.status = {5'h00, maskFlag, 2'h0};
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pcReg <= 16'h0000;
    end else if (vecValid) begin
      pcReg <= vecAddrLo;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pushLog <= 24'h000000;
    end else if (pushValid) begin
      pushLog <= {pushLog[15:0], pushData};
    end
  end
endmodule

/* testbench/vpi_ctrl_monitor.sv */
// Checker of the controller's bus and core sequencing ports.
// Assumes one clock domain; bound to every controller instance.
`timescale 1ns/1ps

module vpi_ctrl_monitor #(
  parameter int NUM_SRC = vpi_pkg::SRC_COUNT
) (
  // Clock and reset
  input wire logic                  clk,
  input wire logic                  sys_rst,
  // Wishbone
  input wire logic                  wb_cyc_i,
  input wire logic                  wb_stb_i,
  input wire logic                  wb_ack_o,
  input wire logic [31:0]           wb_dat_o,
  // Core side
  input wire vpi_pkg::vpi_core_in_t core,
  input wire logic                  busy,
  input wire logic                  pushValid,
  input wire logic [7:0]            pushData,
  input wire logic                  vecValid,
  input wire logic [15:0]           vecAddrLo,
  input wire logic [15:0]           vecAddrHi,
  input wire logic                  maskFlag
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  chk_ack_pulse: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack missing or too long");
  chk_idle_data: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  chk_boundary_only: assert property (
    $rose(busy) |-> $past(core.instrDone)) else $error("accept without boundary");
  chk_push_pc: assert property (
    $rose(busy) |-> pushValid && pushData == $past(core.pc[15:8])
      ##1 pushValid && pushData == $past(core.pc[7:0], 2))
    else $error("program counter push wrong");
  chk_vector_pair: assert property (
    $rose(busy) |=> vecValid && vecAddrHi == vecAddrLo + 16'h0001)
    else $error("vector pair wrong");
  chk_status_first: assert property (
    $rose(busy) |-> ##2 pushValid && pushData[vpi_pkg::PS_MASK_BIT] == maskFlag
      ##1 maskFlag && !busy) else $error("status push or mask set wrong");
  chk_busy_span: assert property ($rose(busy) |-> busy [*3] ##1 !busy)
    else $error("busy span wrong");
  chk_return_mask: assert property (
    core.returnFromTrapInstruction && !busy |=> maskFlag == $past(core.poppedStatus[2]))
    else $error("return did not restore mask");
  chk_set_mask: assert property (
    core.setMaskInstruction && !core.returnFromTrapInstruction && !busy |=> maskFlag)
    else $error("set mask ignored");
  chk_clear_mask: assert property (
    core.clearMaskInstruction && !core.setMaskInstruction
      && !core.returnFromTrapInstruction && !busy |=> !maskFlag)
    else $error("clear mask ignored");
endmodule

bind vpi_ctrl vpi_ctrl_monitor #(.NUM_SRC(NUM_SRC)) i_mon (
  .clk(clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .core(core), .busy(busy),
  .pushValid(pushValid), .pushData(pushData), .vecValid(vecValid),
  .vecAddrLo(vecAddrLo), .vecAddrHi(vecAddrHi), .maskFlag(maskFlag));
